//--- hw/qlsdsc_pkg.sv
// Constants, register map and types shared by the quad low-side driver control block
package qlsdsc_pkg;

   localparam real CLK_MHZ = 100.0;
   localparam int NUM_CH = 4;
   localparam int FRAME_BITS = 8;

   // Fault timing, figures in their own units
   localparam real OC_SENSE_US = 62.5;
   localparam real OC_SHUT_MS = 3.94;
   localparam real OL_SENSE_US = 12.5;
   // Host spacing between frames; kept for the far side, the device needs no timer for it
   localparam real XFER_GAP_US = 1.0;

   // Nominal on-fraction in retry is sense/(sense+shutdown), about 1.56 percent
   localparam int OC_SENSE_CYC = int'($ceil(OC_SENSE_US * CLK_MHZ));
   localparam int OC_SHUT_CYC = int'($floor(OC_SHUT_MS * 1000.0 * CLK_MHZ + 0.001));
   localparam int OL_SENSE_CYC = int'($ceil(OL_SENSE_US * CLK_MHZ));

   // AXI4-Lite register map
   localparam int AXI_AW = 4;
   localparam logic [AXI_AW-1:0] REG_CTRL_OFS = 4'h0;
   localparam logic [AXI_AW-1:0] REG_STATUS_OFS = 4'h4;
   localparam logic [AXI_AW-1:0] REG_CMD_OFS = 4'h8;
   localparam logic [NUM_CH-1:0] CTRL_PAR_EN_RST = 4'hf;
   localparam logic [FRAME_BITS-1:0] CMD_RST = 8'h00;
   localparam int ST_OC_LSB = 0;
   localparam int ST_OL_LSB = 4;
   localparam int ST_DRV_LSB = 8;
   localparam int ST_SUPPLY_BIT = 12;
   localparam int ST_SEL_BIT = 13;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {REG_CTRL, REG_STATUS, REG_CMD, REG_NONE} qlsdsc_reg_t;
   typedef enum logic [1:0] {CH_NORMAL, CH_SHUTDOWN, CH_RETRY} qlsdsc_ch_st_t;

endpackage : qlsdsc_pkg

//--- hw/qlsdsc_chan.sv
// One output channel: overcurrent retry timing and open-load qualification
`timescale 1ns/1ps
module qlsdsc_chan
   import qlsdsc_pkg::*;
#(
   parameter int SENSE_CYC = OC_SENSE_CYC,
   parameter int SHUT_CYC = OC_SHUT_CYC,
   parameter int OL_CYC = OL_SENSE_CYC,
   parameter int CW = $clog2(SHUT_CYC + 1)
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic on_req,
   input wire logic oc_sense,
   input wire logic ol_sense,
   output logic gate_ok,
   output logic oc_flag,
   output logic ol_flag
);

   localparam logic [CW-1:0] SENSE_LAST = CW'(SENSE_CYC - 1);
   localparam logic [CW-1:0] SHUT_LAST = CW'(SHUT_CYC - 1);
   localparam logic [CW-1:0] OL_LAST = CW'(OL_CYC - 1);

   qlsdsc_ch_st_t st_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] ol_cnt_q;

   assign gate_ok = (st_q != CH_SHUTDOWN);

   // Overcurrent is only looked at while the channel is asked to be on
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= CH_NORMAL;
         cnt_q <= '0;
         oc_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         unique case (st_q)
            CH_NORMAL:
               if (on_req && oc_sense)
               begin
                  if (cnt_q == SENSE_LAST)
                  begin
                     st_q <= CH_SHUTDOWN;
                     cnt_q <= '0;
                     oc_flag <= 1'b1;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               end
               else
                  cnt_q <= '0;
            CH_SHUTDOWN:
               if (cnt_q == SHUT_LAST)
               begin
                  st_q <= CH_RETRY;
                  cnt_q <= '0;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            CH_RETRY:
               // One clean on-sample ends the fault; a persisting one repeats the cycle
               if (!on_req || !oc_sense)
               begin
                  st_q <= CH_NORMAL;
                  cnt_q <= '0;
                  oc_flag <= 1'b0;
               end
               else if (cnt_q == SENSE_LAST)
               begin
                  st_q <= CH_SHUTDOWN;
                  cnt_q <= '0;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
         endcase
      end
   end

   // Open load or short to ground is qualified only while the channel is off
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ol_cnt_q <= '0;
         ol_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!on_req && ol_sense)
         begin
            if (ol_cnt_q == OL_LAST)
               ol_flag <= 1'b1;
            else
               ol_cnt_q <= ol_cnt_q + 1'b1;
         end
         else
         begin
            ol_cnt_q <= '0;
            ol_flag <= 1'b0;
         end
      end
   end

   default clocking ch_cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   oc_trip_a: assert property (
      (st_q == CH_NORMAL && clk_en && on_req && oc_sense && cnt_q == SENSE_LAST)
      |=> (st_q == CH_SHUTDOWN && oc_flag && !gate_ok))
      else $error("overcurrent did not trip after the sense interval");
   shut_end_a: assert property (
      (st_q == CH_SHUTDOWN && clk_en && cnt_q == SHUT_LAST) |=> (st_q == CH_RETRY && gate_ok))
      else $error("shutdown interval did not end on time");
   ol_clear_a: assert property (
      (clk_en && !ol_sense) |=> !ol_flag)
      else $error("open-load flag stayed after condition left");
   ol_trip_a: assert property (
      $rose(ol_flag) |-> ($past(ol_cnt_q) == OL_LAST && $past(!on_req)))
      else $error("open-load flag raised before qualification");
   retry_cov: cover property ((st_q == CH_RETRY) ##1 (st_q == CH_SHUTDOWN));

endmodule : qlsdsc_chan

//--- hw/qlsdsc_top.sv
// Serial control, diagnosis and supply shutoff of a quad protected low-side driver
`timescale 1ns/1ps
// Notes on behaviour
// - Serial input sampled on rising serial clock.
// - Eight-bit frames, most significant bit first.
// - Outputs hold; new command applies at select rise.
// - Next status bit driven on falling clock.
// - Serial output released while select is high.
// - Fault indicator pulled low on overcurrent or open load.
// - On checks overcurrent; off checks open/ground.
// - Fault flags follow condition, clear themselves.
// - Fault snapshot taken at select fall.
// - Overcurrent puts channel into low-duty retry.
// - Retry keeps channel on about 1.56 percent.
// - Overcurrent must persist sense interval first.
// - Shutdown interval nominally 3.94 ms.
// - Open load qualified over sense interval.
// - Supply fault forces all outputs off.
// - Reset or supply event latches serial command off.
// - Serial bit and parallel input control channel.
module qlsdsc_top
   import qlsdsc_pkg::*;
#(
   parameter int SENSE_CYC = OC_SENSE_CYC,
   parameter int SHUT_CYC = OC_SHUT_CYC,
   parameter int OL_CYC = OL_SENSE_CYC
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic sclk_pin,
   input wire logic select_low,
   input wire logic serial_in,
   output logic serial_out_o,
   output logic serial_out_oe,
   input wire logic parallel_ctl_0,
   input wire logic parallel_ctl_1,
   input wire logic parallel_ctl_2,
   input wire logic parallel_ctl_3,
   output logic drive_0,
   output logic drive_1,
   output logic drive_2,
   output logic drive_3,
   output logic fault_ind_o,
   output logic fault_ind_oe,
   input wire logic [NUM_CH-1:0] overcurrent_sense,
   input wire logic [NUM_CH-1:0] open_load_sense,
   input wire logic load_supply_uv,
   input wire logic load_supply_ov,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int PIN_W = 3 + 3 * NUM_CH + 2;
   localparam logic [3:0] FRAME_CNT = 4'(FRAME_BITS);
   localparam logic [3:0] CNT_SAT = 4'hf;

   function automatic qlsdsc_reg_t reg_decode(input logic [AXI_AW-1:0] a);
      if (a == REG_CTRL_OFS)
         return REG_CTRL;
      else if (a == REG_STATUS_OFS)
         return REG_STATUS;
      else if (a == REG_CMD_OFS)
         return REG_CMD;
      else
         return REG_NONE;
   endfunction : reg_decode

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1_q;
   logic [PIN_W-1:0] sync2_q;
   logic sclk_s, sel_s, si_s, uv_s, ov_s;
   logic [NUM_CH-1:0] par_s, oc_s, ol_s;
   logic sclk_d_q, sel_d_q;
   logic sclk_rise, sclk_fall, sel_fall, sel_rise, selected;
   logic [FRAME_BITS-1:0] rx_q;
   logic [3:0] bit_cnt_q;
   logic [FRAME_BITS-1:0] so_shift_q;
   logic [FRAME_BITS-1:0] cmd_q;
   logic supply_bad, supply_bad_q;
   logic [NUM_CH-1:0] par_en_q;
   logic [NUM_CH-1:0] on_req, gate_ok, oc_flag, ol_flag, fault_all;
   logic [NUM_CH-1:0] drive_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_got_q, w_got_q, wr_fire;
   qlsdsc_reg_t wr_reg;

   assign pin_raw = {load_supply_ov, load_supply_uv, open_load_sense, overcurrent_sense,
                     parallel_ctl_3, parallel_ctl_2, parallel_ctl_1, parallel_ctl_0,
                     serial_in, select_low, sclk_pin};

   // Two flops per pin; select starts at its idle high so reset fakes no frame start
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_q <= {{(PIN_W - 2){1'b0}}, 2'h2};
         sync2_q <= {{(PIN_W - 2){1'b0}}, 2'h2};
      end
      else if (clk_en)
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   assign {ov_s, uv_s, ol_s, oc_s, par_s, si_s, sel_s, sclk_s} = sync2_q;

   // Select idles high, so its delayed copy resets high to avoid a false frame start
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_d_q <= 1'b0;
         sel_d_q <= 1'b1;
      end
      else if (clk_en)
      begin
         sclk_d_q <= sclk_s;
         sel_d_q <= sel_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_q;
   assign sclk_fall = ~sclk_s & sclk_d_q;
   assign sel_fall = ~sel_s & sel_d_q;
   assign sel_rise = sel_s & ~sel_d_q;
   assign selected = ~sel_s & ~sel_d_q;

   // Receive shifter; a frame of any length other than eight is discarded
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_q <= '0;
         bit_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (sel_fall)
            bit_cnt_q <= '0;
         else if (selected && sclk_rise)
         begin
            rx_q <= {rx_q[FRAME_BITS-2:0], si_s};
            if (bit_cnt_q != CNT_SAT)
               bit_cnt_q <= bit_cnt_q + 1'b1;
         end
      end
   end

   // Transmit shifter and its enable
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         so_shift_q <= '0;
         serial_out_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         if (sel_fall)
         begin
            so_shift_q <= {{(FRAME_BITS - NUM_CH){1'b0}}, fault_all};
            serial_out_oe <= 1'b1;
         end
         else if (sel_rise)
            serial_out_oe <= 1'b0;
         else if (selected && sclk_fall)
            so_shift_q <= {so_shift_q[FRAME_BITS-2:0], 1'b0};
      end
   end

   assign serial_out_o = so_shift_q[FRAME_BITS-1];

   assign supply_bad = uv_s | ov_s;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         supply_bad_q <= 1'b0;
      else if (clk_en)
         supply_bad_q <= supply_bad;
   end

   // Command stays put while shifting; a supply event wipes it so only a new full frame or an enabled parallel input can turn outputs on
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cmd_q <= CMD_RST;
      else if (clk_en)
      begin
         if (supply_bad && !supply_bad_q)
            cmd_q <= CMD_RST;
         else if (sel_rise && bit_cnt_q == FRAME_CNT)
            cmd_q <= rx_q;
      end
   end

   assign on_req = cmd_q[NUM_CH-1:0] | (par_s & par_en_q);
   assign fault_all = oc_flag | ol_flag;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         qlsdsc_chan #(
            .SENSE_CYC(SENSE_CYC),
            .SHUT_CYC(SHUT_CYC),
            .OL_CYC(OL_CYC)
         ) u_chan (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .clk_en(clk_en),
            .on_req(on_req[gi]),
            .oc_sense(oc_s[gi]),
            .ol_sense(ol_s[gi]),
            .gate_ok(gate_ok[gi]),
            .oc_flag(oc_flag[gi]),
            .ol_flag(ol_flag[gi])
         );
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         drive_q <= '0;
         fault_ind_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         drive_q <= on_req & gate_ok & {NUM_CH{~supply_bad}};
         fault_ind_oe <= |fault_all;
      end
   end

   assign {drive_3, drive_2, drive_1, drive_0} = drive_q;
   // Open drain: the pin is only ever pulled low
   assign fault_ind_o = 1'b0;

   // AXI4-Lite write: address and data taken in either order, one write at a time
   assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
   assign wr_reg = reg_decode(awaddr_q);

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Parallel-input enable mask; status and command words are read only
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         par_en_q <= CTRL_PAR_EN_RST;
      else if (clk_en && wr_fire && wr_reg == REG_CTRL && wstrb_q[0])
         par_en_q <= wdata_q[NUM_CH-1:0];
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            unique case (reg_decode(s_axi_araddr))
               REG_CTRL:
                  s_axi_rdata[NUM_CH-1:0] <= par_en_q;
               REG_STATUS:
               begin
                  s_axi_rdata[ST_OC_LSB +: NUM_CH] <= oc_flag;
                  s_axi_rdata[ST_OL_LSB +: NUM_CH] <= ol_flag;
                  s_axi_rdata[ST_DRV_LSB +: NUM_CH] <= drive_q;
                  s_axi_rdata[ST_SUPPLY_BIT] <= supply_bad;
                  s_axi_rdata[ST_SEL_BIT] <= selected;
               end
               REG_CMD:
                  s_axi_rdata[FRAME_BITS-1:0] <= cmd_q;
               REG_NONE:
                  s_axi_rresp <= RESP_SLVERR;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   default clocking top_cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   so_release_a: assert property (
      (clk_en && sel_rise) |=> !serial_out_oe)
      else $error("serial output still driven after deselect");
   snap_take_a: assert property (
      (clk_en && sel_fall) |=> (serial_out_oe && so_shift_q == {4'h0, $past(fault_all)}))
      else $error("fault snapshot not taken at select fall");
   rx_shift_a: assert property (
      (clk_en && selected && sclk_rise) |=> (rx_q[0] == $past(si_s)
         && rx_q[FRAME_BITS-1:1] == $past(rx_q[FRAME_BITS-2:0])))
      else $error("serial input not shifted in msb first");
   so_shift_a: assert property (
      (clk_en && selected && sclk_fall && !sel_fall) |=> serial_out_o == $past(so_shift_q[6]))
      else $error("next status bit not presented on falling clock");
   cmd_hold_a: assert property (
      (clk_en && !sel_rise && !(supply_bad && !supply_bad_q)) |=> $stable(cmd_q))
      else $error("command changed outside select rise");
   cmd_apply_a: assert property (
      (clk_en && sel_rise && bit_cnt_q == FRAME_CNT && !(supply_bad && !supply_bad_q))
      |=> cmd_q == $past(rx_q))
      else $error("complete frame not applied at select rise");
   latch_off_a: assert property (
      (clk_en && supply_bad && !supply_bad_q) |=> (cmd_q == CMD_RST && drive_q == '0))
      else $error("supply event did not latch outputs off");
   supply_off_a: assert property (
      (clk_en && supply_bad) |=> drive_q == '0)
      else $error("outputs on during supply fault");
   status_pin_a: assert property (
      (clk_en && |fault_all) |=> fault_ind_oe)
      else $error("fault indicator not pulled on fault");
   par_ctl_a: assert property (
      (clk_en && par_s[0] && par_en_q[0] && gate_ok[0] && !supply_bad) |=> drive_q[0])
      else $error("parallel input did not switch channel on");

   frame_cov: cover property (clk_en && sel_rise && bit_cnt_q == FRAME_CNT);
   fault_snap_cov: cover property (clk_en && sel_fall && |fault_all);
   latch_cov: cover property (clk_en && supply_bad && !supply_bad_q && cmd_q != CMD_RST);

endmodule : qlsdsc_top

//--- sim/qlsdsc_host.sv
// Host model: serial bus master that sends command frames and gathers status bits
`timescale 1ns/1ps
module qlsdsc_host
   import qlsdsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic so_line,
   output logic sclk_pin,
   output logic select_low,
   output logic serial_in
);
   initial
   begin
      sclk_pin = 1'b0;
      select_low = 1'b1;
      serial_in = 1'b0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tk

   // Clock idles low between frames; n below 8 gives a deliberately short frame
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      logic [7:0] t;
      rx = 8'h00;
      t = tx;
      @(posedge ref_clk);
      select_low <= 1'b0;
      serial_in <= t[7];
      tk(6);
      for (int i = 0; i < n; i++)
      begin
         sclk_pin <= 1'b1;
         tk(1);
         // Sampled a cycle after the rise, well after the output bit settled
         rx = {rx[6:0], so_line};
         tk(3);
         t = t << 1;
         sclk_pin <= 1'b0;
         serial_in <= t[7];
         tk(4);
      end
      tk(4);
      select_low <= 1'b1;
      serial_in <= 1'b0;
      tk(int'(XFER_GAP_US * CLK_MHZ));
   endtask : xfer
endmodule : qlsdsc_host

//--- sim/tb.sv
// Self-checking bench of the quad low-side driver control block
`timescale 1ns/1ps
module tb;
   import qlsdsc_pkg::*;
   typedef struct packed {logic [7:0] cmd; logic [3:0] par; logic [3:0] drv;} qlsdsc_row_t;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] par = 4'h0;
   logic [3:0] oc = 4'h0;
   logic [3:0] ol = 4'h0;
   logic uv = 1'b0;
   logic ov = 1'b0;
   logic clk_en = 1'b1;
   logic sclk_pin, select_low, serial_in, serial_out_o, serial_out_oe, fault_ind_o, fault_ind_oe;
   logic drive_0, drive_1, drive_2, drive_3;
   logic so_last = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdat;
   logic [7:0] rx;
   logic [3:0] prev;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   // Released line shows the inverse of its last value so a stale bit cannot pass
   wire so_line = serial_out_oe ? serial_out_o : ~so_last;
   wire [3:0] drv = {drive_3, drive_2, drive_1, drive_0};
   qlsdsc_row_t rows [5] = '{'{8'h05, 4'h0, 4'h5}, '{8'ha0, 4'h2, 4'h2},
      '{8'h0a, 4'h4, 4'he}, '{8'h00, 4'h1, 4'h1}, '{8'h00, 4'h0, 4'h0}};

   qlsdsc_top #(.SENSE_CYC(8), .SHUT_CYC(40), .OL_CYC(5)) i_qlsdsc_top (
      .ref_clk, .sys_rst, .clk_en, .sclk_pin, .select_low, .serial_in,
      .serial_out_o, .serial_out_oe, .parallel_ctl_0(par[0]), .parallel_ctl_1(par[1]),
      .parallel_ctl_2(par[2]), .parallel_ctl_3(par[3]), .drive_0, .drive_1, .drive_2,
      .drive_3, .fault_ind_o, .fault_ind_oe, .overcurrent_sense(oc), .open_load_sense(ol),
      .load_supply_uv(uv), .load_supply_ov(ov), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   qlsdsc_host i_qlsdsc_host (.ref_clk, .so_line, .sclk_pin, .select_low, .serial_in);

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      if (serial_out_oe)
         so_last <= serial_out_o;
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         final_report();
      end
   end

   task automatic tk(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : tk

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   initial
   begin
      tk(16);
      chk(drv, 4'h0);
      chk(serial_out_oe, 1'b0);
      chk(fault_ind_o, 1'b0);
      sys_rst <= 1'b0;
      tk(5);
      rd(REG_CTRL_OFS);
      chk(rdat, CTRL_PAR_EN_RST);
      rd(4'hc);
      chk(rsp, RESP_SLVERR);
      wr(4'hc, 32'h0000_0001);
      chk(rsp, RESP_SLVERR);
      // Masked parallel inputs must not reach the outputs
      wr(REG_CTRL_OFS, 32'h0000_0000);
      par <= 4'hf;
      tk(10);
      chk(drv, 4'h0);
      wr(REG_CTRL_OFS, 32'h0000_000f);
      par <= 4'h0;
      prev = 4'h0;
      $display("reset and register test done");
      foreach (rows[i])
      begin
         fork
            i_qlsdsc_host.xfer(rows[i].cmd, 8, rx);
            begin
               tk(40);
               chk(drv, prev);
            end
         join
         chk(rx, 8'h00);
         chk(serial_out_oe, 1'b0);
         par <= rows[i].par;
         tk(10);
         chk(drv, rows[i].drv);
         rd(REG_CMD_OFS);
         chk(rdat, rows[i].cmd);
         prev = rows[i].drv;
      end
      $display("command table test done");
      i_qlsdsc_host.xfer(8'h0f, 5, rx);
      rd(REG_CMD_OFS);
      chk(rdat, 32'h0000_0000);
      $display("short frame test done");
      par <= 4'h1;
      ol <= 4'h5;
      tk(20);
      chk(fault_ind_oe, 1'b1);
      rd(REG_STATUS_OFS);
      chk(rdat[7:4], 4'h4);
      chk(rdat[11:8], 4'h1);
      i_qlsdsc_host.xfer(8'h01, 8, rx);
      chk(rx, 8'h04);
      ol <= 4'h0;
      tk(10);
      chk(fault_ind_oe, 1'b0);
      ol <= 4'h4;
      tk(4);
      ol <= 4'h0;
      repeat (8)
      begin
         tk(1);
         chk(fault_ind_oe, 1'b0);
      end
      $display("open load test done");
      par <= 4'h2;
      tk(10);
      oc <= 4'h2;
      n = 0;
      while (drive_1 === 1'b1 && n < 40)
      begin
         tk(1);
         n++;
      end
      chk(n inside {[8:14]}, 1'b1);
      chk(fault_ind_oe, 1'b1);
      n = 0;
      while (drive_1 === 1'b0 && n < 100)
      begin
         tk(1);
         n++;
      end
      chk(n inside {[38:44]}, 1'b1);
      n = 0;
      while (drive_1 === 1'b1 && n < 40)
      begin
         tk(1);
         n++;
      end
      chk(n inside {[7:10]}, 1'b1);
      oc <= 4'h0;
      tk(60);
      chk(drive_1, 1'b1);
      chk(fault_ind_oe, 1'b0);
      oc <= 4'h2;
      tk(5);
      oc <= 4'h0;
      repeat (20)
      begin
         tk(1);
         chk(drive_1, 1'b1);
      end
      $display("overcurrent test done");
      for (int k = 0; k < 2; k++)
      begin
         par <= 4'h0;
         i_qlsdsc_host.xfer(8'h0f, 8, rx);
         chk(drv, 4'hf);
         uv <= (k == 0);
         ov <= (k == 1);
         tk(8);
         chk(drv, 4'h0);
         uv <= 1'b0;
         ov <= 1'b0;
         tk(8);
         chk(drv, 4'h0);
         par <= 4'h8;
         tk(8);
         chk(drv, 4'h8);
      end
      $display("supply test done");
      i_qlsdsc_host.xfer(8'h03, 8, rx);
      chk(drv, 4'hb);
      sys_rst <= 1'b1;
      tk(2);
      chk(drv, 4'h0);
      sys_rst <= 1'b0;
      par <= 4'h0;
      repeat (8)
      begin
         tk(1);
         chk(serial_out_oe, 1'b0);
      end
      chk(drv, 4'h0);
      clk_en <= 1'b0;
      par <= 4'h4;
      tk(10);
      chk(drv, 4'h0);
      clk_en <= 1'b1;
      tk(6);
      chk(drv, 4'h4);
      $display("reset and enable test done");
      final_report();
   end
endmodule : tb
